// File: rtl/fault_pkg.sv
// Package with the constants and carrier types of the fault checker.
package fault_pkg;

  localparam int unsigned ADDR_W = 32;

  localparam logic [1:0] DESC_INVALID   = 2'h0;
  localparam logic [1:0] L2_LARGE       = 2'h1;
  localparam logic [1:0] L2_SMALL       = 2'h2;
  localparam logic [1:0] L2_TINY        = 2'h3;
  localparam logic [1:0] L1_SECTION     = 2'h2;
  localparam logic [1:0] L1_COARSE      = 2'h1;

  localparam int unsigned L1_DOM_LSB    = 5;
  localparam int unsigned L1_SEC_AP_LSB = 10;
  localparam int unsigned L2_AP_LSB     = 4;
  localparam int unsigned TINY_AP_LSB   = 4;
  localparam int unsigned SMALL_Q_LSB   = 10;
  localparam int unsigned LARGE_Q_LSB   = 14;

  localparam logic [1:0] DOM_NONE       = 2'h0;
  localparam logic [1:0] DOM_CLIENT     = 2'h1;
  localparam logic [1:0] DOM_RSVD       = 2'h2;
  localparam logic [1:0] DOM_MANAGER    = 2'h3;

  localparam logic [1:0] AP_SPECIAL     = 2'h0;
  localparam logic [1:0] AP_SUPER_RW    = 2'h1;
  localparam logic [1:0] AP_USER_RO     = 2'h2;

  localparam logic [3:0] FS_NONE        = 4'h0;
  localparam logic [3:0] FS_ALIGN       = 4'h1;
  localparam logic [3:0] FS_TRANS_SEC   = 4'h5;
  localparam logic [3:0] FS_TRANS_PAGE  = 4'h7;
  localparam logic [3:0] FS_DOM_SEC     = 4'h9;
  localparam logic [3:0] FS_DOM_PAGE    = 4'hb;
  localparam logic [3:0] FS_PERM_SEC    = 4'hd;
  localparam logic [3:0] FS_PERM_PAGE   = 4'hf;
  localparam logic [3:0] FS_EXT_SEC     = 4'h8;
  localparam logic [3:0] FS_EXT_PAGE    = 4'ha;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_HALF = 2'b01,
    SIZE_WORD = 2'b10
  } acc_size_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    acc_size_t         size;
    logic              write;
    logic              user;
    logic              fetch;
    logic              cachable;
    logic              bufferable;
    logic              locked;
  } access_t;

  typedef struct packed {
    logic        mmu_en;
    logic        align_en;
    logic        dcache_en;
    logic        sys_prot;
    logic        rom_prot;
    logic [31:0] dom_ctrl;
  } ctrl_t;

  typedef struct packed {
    logic [3:0] code;
    logic [3:0] domain;
  } fault_t;

endpackage

// File: rtl/perm_judge.sv
// Judges one access against a two-bit access permission field.
`timescale 1ns/1ns
module perm_judge
  import fault_pkg::*;
(
  input  wire logic [1:0] ap_i,
  input  wire logic       sys_prot_i,
  input  wire logic       rom_prot_i,
  input  wire logic       user_i,
  input  wire logic       write_i,
  output logic            allowed_o
);

  always_comb begin
    allowed_o = 1'b1;
    if (sys_prot_i && rom_prot_i) begin
      allowed_o = 1'b0;
    end else begin
      unique case (ap_i)
        AP_SPECIAL: begin
          if (sys_prot_i) begin
            allowed_o = !user_i && !write_i;
          end else if (rom_prot_i) begin
            allowed_o = !write_i;
          end else begin
            allowed_o = 1'b0;
          end
        end
        AP_SUPER_RW: allowed_o = !user_i;
        AP_USER_RO:  allowed_o = !user_i || !write_i;
        default:     allowed_o = 1'b1;
      endcase
    end
  end

endmodule

// File: rtl/mmu_fault_checker.sv
// Fault checker that judges each core access and returns an abort.
// Summary of operation
// - Alignment enabled faults misaligned word, halfword data.
// - Never align-fault fetches or byte accesses.
// - Misaligned access aborts, skipping later checks.
// - First-level descriptor low bits zero: section fault.
// - Second-level descriptor low bits zero: page fault.
// - Domain number selects one of sixteen fields.
// - Domain checked once first-level descriptor returns.
// - No-access or reserved domain gives domain fault.
// - Client domain proceeds to permission check.
// - Section permission uses bits plus system, ROM.
// - Large, small pages use four quarter fields.
// - Small page quarter picked by 1KB address.
// - Large page quarter picked by 16KB address.
// - Page permission violation reported as page fault.
// - Tiny page uses first-level bits, page fault.
// - External abort honoured only on uncached synchronous accesses.
// - Aborted swap read suppresses its write phase.
// - Translation checks only while translation enabled.
// - Prefetched instructions keep their flat addresses.
// - Manager domain skips permission check.
// - Permission encodings one, two, three, zero special.
// - Highest-priority fault reported as four-bit code.
`timescale 1ns/1ns
module mmu_fault_checker
  import fault_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        req_valid_i,
  input  wire access_t     req_i,
  input  wire ctrl_t       ctrl_i,
  input  wire logic        l1_valid_i,
  input  wire logic [31:0] l1_desc_i,
  input  wire logic        l2_valid_i,
  input  wire logic [31:0] l2_desc_i,
  input  wire logic        bus_done_i,
  input  wire logic        bus_error_i,
  output logic             walk_l1_o,
  output logic             walk_l2_o,
  output logic             bus_req_o,
  output logic             done_o,
  output logic             abort_o,
  output fault_t           fault_o,
  output logic [31:0]      phys_addr_o
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_L1   = 3'b001,
    ST_L2   = 3'b010,
    ST_BUS  = 3'b011,
    ST_SWPW = 3'b100
  } state_t;

  logic    rst_meta;
  logic    rst_sync_n;
  state_t  state;
  access_t acc;
  logic    mmu_on;
  logic    sec_map;
  logic [31:0] l1_held;
  logic [1:0]  dom_field;
  logic [3:0]  dom_num;
  logic [1:0]  l2_ap;
  logic [1:0]  quarter;
  logic        sec_ok;
  logic        page_ok;
  logic        ext_honour;

  function automatic logic misaligned(input access_t a, input logic en);
    misaligned = en && !a.fetch &&
      ((a.size == SIZE_WORD && a.addr[1:0] != 2'h0) ||
       (a.size == SIZE_HALF && a.addr[0]));
  endfunction

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Domain field selected by the descriptor's domain number.
  assign dom_num   = l1_desc_i[L1_DOM_LSB +: 4];
  assign dom_field = ctrl_i.dom_ctrl[{dom_num, 1'b0} +: 2];

  assign quarter = (l2_desc_i[1:0] == L2_LARGE) ?
                   acc.addr[LARGE_Q_LSB +: 2] :
                   acc.addr[SMALL_Q_LSB +: 2];
  assign l2_ap = (l2_desc_i[1:0] == L2_TINY) ?
                 l1_held[TINY_AP_LSB +: 2] :
                 l2_desc_i[{quarter, 1'b0} + L2_AP_LSB +: 2];

  perm_judge u_sec_judge (
    .ap_i       (l1_desc_i[L1_SEC_AP_LSB +: 2]),
    .sys_prot_i (ctrl_i.sys_prot),
    .rom_prot_i (ctrl_i.rom_prot),
    .user_i     (acc.user),
    .write_i    (acc.write),
    .allowed_o  (sec_ok)
  );

  perm_judge u_page_judge (
    .ap_i       (l2_ap),
    .sys_prot_i (ctrl_i.sys_prot),
    .rom_prot_i (ctrl_i.rom_prot),
    .user_i     (acc.user),
    .write_i    (acc.write),
    .allowed_o  (page_ok)
  );

  // Only accesses synchronised to the bus can take an external abort.
  assign ext_honour = !acc.cachable &&
                      (!acc.write || !acc.bufferable || acc.locked);

  assign walk_l1_o = (state == ST_L1);
  assign walk_l2_o = (state == ST_L2);
  assign bus_req_o = (state == ST_BUS) || (state == ST_SWPW);

  function automatic logic [1:0] dom_field_held();
    dom_field_held = ctrl_i.dom_ctrl[{l1_held[L1_DOM_LSB +: 4], 1'b0} +: 2];
  endfunction

  // The access sequencer; alignment, translation, domain and permission faults end the access before the bus phase.
  always_ff @(posedge core_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state       <= ST_IDLE;
      acc         <= '0;
      mmu_on      <= 1'b0;
      sec_map     <= 1'b0;
      l1_held     <= 32'h0000_0000;
      done_o      <= 1'b0;
      abort_o     <= 1'b0;
      fault_o     <= '0;
      phys_addr_o <= 32'h0000_0000;
    end else begin
      done_o  <= 1'b0;
      abort_o <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (req_valid_i) begin
            acc    <= req_i;
            // Enable sampled per access so earlier fetches stay flat.
            mmu_on <= ctrl_i.mmu_en;
            if (misaligned(req_i, ctrl_i.align_en)) begin
              done_o  <= 1'b1;
              abort_o <= 1'b1;
              fault_o <= '{code: FS_ALIGN, domain: 4'h0};
            end else if (ctrl_i.mmu_en) begin
              state <= ST_L1;
            end else begin
              phys_addr_o <= req_i.addr;
              state       <= ST_BUS;
            end
          end
        end
        ST_L1: begin
          if (l1_valid_i) begin
            l1_held <= l1_desc_i;
            sec_map <= (l1_desc_i[1:0] == L1_SECTION);
            if (l1_desc_i[1:0] == DESC_INVALID ||
                l1_desc_i[1:0] == L2_TINY) begin
              done_o  <= 1'b1;
              abort_o <= 1'b1;
              fault_o <= '{code: FS_TRANS_SEC, domain: 4'h0};
              state   <= ST_IDLE;
            end else if (dom_field == DOM_NONE ||
                         dom_field == DOM_RSVD) begin
              done_o  <= 1'b1;
              abort_o <= 1'b1;
              fault_o <= '{code: (l1_desc_i[1:0] == L1_SECTION) ?
                           FS_DOM_SEC : FS_DOM_PAGE, domain: dom_num};
              state   <= ST_IDLE;
            end else if (l1_desc_i[1:0] == L1_SECTION) begin
              if (dom_field == DOM_CLIENT && !sec_ok) begin
                done_o  <= 1'b1;
                abort_o <= 1'b1;
                fault_o <= '{code: FS_PERM_SEC, domain: dom_num};
                state   <= ST_IDLE;
              end else begin
                phys_addr_o <= {l1_desc_i[31:20], acc.addr[19:0]};
                fault_o     <= '{code: FS_NONE, domain: dom_num};
                state       <= ST_BUS;
              end
            end else begin
              fault_o <= '{code: FS_NONE, domain: dom_num};
              state   <= ST_L2;
            end
          end
        end
        ST_L2: begin
          if (l2_valid_i) begin
            if (l2_desc_i[1:0] == DESC_INVALID) begin
              done_o       <= 1'b1;
              abort_o      <= 1'b1;
              fault_o.code <= FS_TRANS_PAGE;
              state        <= ST_IDLE;
            end else if (dom_field_held() == DOM_CLIENT && !page_ok) begin
              done_o       <= 1'b1;
              abort_o      <= 1'b1;
              fault_o.code <= FS_PERM_PAGE;
              state        <= ST_IDLE;
            end else begin
              unique case (l2_desc_i[1:0])
                L2_LARGE: phys_addr_o <= {l2_desc_i[31:16], acc.addr[15:0]};
                L2_SMALL: phys_addr_o <= {l2_desc_i[31:12], acc.addr[11:0]};
                default:  phys_addr_o <= {l2_desc_i[31:10], acc.addr[9:0]};
              endcase
              state <= ST_BUS;
            end
          end
        end
        ST_BUS: begin
          if (bus_done_i) begin
            if (bus_error_i && ext_honour) begin
              done_o       <= 1'b1;
              abort_o      <= 1'b1;
              fault_o.code <= (mmu_on && !sec_map) ? FS_EXT_PAGE
                                                   : FS_EXT_SEC;
              state        <= ST_IDLE;
            end else if (acc.locked && !acc.write) begin
              state <= ST_SWPW;
            end else begin
              done_o <= 1'b1;
              state  <= ST_IDLE;
            end
          end
        end
        ST_SWPW: begin
          if (bus_done_i) begin
            done_o  <= 1'b1;
            abort_o <= bus_error_i && ext_honour;
            if (bus_error_i && ext_honour) begin
              fault_o.code <= (mmu_on && !sec_map) ? FS_EXT_PAGE : FS_EXT_SEC;
            end
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end


  a_align_abort: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_IDLE && req_valid_i && misaligned(req_i, ctrl_i.align_en))
    |=> (abort_o && fault_o.code == FS_ALIGN && state == ST_IDLE))
    else $error("Misaligned access not aborted.");

  a_fetch_noalign: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_IDLE && req_valid_i && (req_i.fetch ||
     req_i.size == SIZE_BYTE)) |=> !(abort_o && fault_o.code == FS_ALIGN))
    else $error("Alignment fault on fetch or byte.");

  a_l1_invalid: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_L1 && l1_valid_i && l1_desc_i[1:0] == DESC_INVALID)
    |=> (abort_o && fault_o.code == FS_TRANS_SEC))
    else $error("Invalid first-level descriptor not faulted.");

  a_l2_invalid: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_L2 && l2_valid_i && l2_desc_i[1:0] == DESC_INVALID)
    |=> (abort_o && fault_o.code == FS_TRANS_PAGE))
    else $error("Invalid second-level descriptor not faulted.");

  a_dom_fault: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_L1 && l1_valid_i && l1_desc_i[1:0] != DESC_INVALID &&
     l1_desc_i[1:0] != L2_TINY &&
     (dom_field == DOM_NONE || dom_field == DOM_RSVD))
    |=> (abort_o && (fault_o.code == FS_DOM_SEC ||
                     fault_o.code == FS_DOM_PAGE)))
    else $error("No-access domain not faulted.");

  a_no_mmu_walk: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_IDLE && !ctrl_i.mmu_en) |=> !walk_l1_o)
    else $error("Walk started with translation off.");

  a_fault_nobus: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (abort_o && fault_o.code[0]) |-> !bus_req_o)
    else $error("Bus access during fault.");

  a_swap_stop: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_BUS && bus_done_i && bus_error_i && ext_honour)
    |=> (state == ST_IDLE) ##1 (state != ST_SWPW))
    else $error("Swap write issued after aborted read.");

  a_ext_ignore: assert property (@(posedge core_clk_i)
    disable iff (!rst_sync_n)
    (state == ST_BUS && bus_done_i && !ext_honour) |=> !abort_o)
    else $error("External abort taken on cached access.");

  c_section_ok: cover property (@(posedge core_clk_i)
    state == ST_L1 ##1 state == ST_BUS);
  c_page_perm: cover property (@(posedge core_clk_i)
    abort_o && fault_o.code == FS_PERM_PAGE);
  c_dom_fault: cover property (@(posedge core_clk_i)
    abort_o && fault_o.code == FS_DOM_SEC);
  c_swap_done: cover property (@(posedge core_clk_i)
    state == ST_SWPW ##1 done_o);

endmodule

// File: testbench/core_mem_model.sv
// Model of the descriptor walker and external bus facing the checker.
`timescale 1ns/1ns
module core_mem_model
  import fault_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        walk_l1_i,
  input  wire logic        walk_l2_i,
  input  wire logic        bus_req_i,
  input  wire logic [31:0] l1_word_i,
  input  wire logic [31:0] l2_word_i,
  input  wire logic        err_i,
  input  wire logic [1:0]  delay_i,
  output logic             l1_valid_o,
  output logic [31:0]      l1_desc_o,
  output logic             l2_valid_o,
  output logic [31:0]      l2_desc_o,
  output logic             bus_done_o,
  output logic             bus_error_o
);
  logic [1:0] wait_cnt = 2'h0;
  logic       phase = 1'b0;
  initial begin
    {l1_valid_o, l2_valid_o, bus_done_o, bus_error_o} = 4'h0;
    l1_desc_o = 32'h0;
    l2_desc_o = 32'h0;
  end
  // Unqualified lines show inverted data so stale values never pass.
  always @(negedge clk_i) begin
    l1_valid_o <= 1'b0;
    l2_valid_o <= 1'b0;
    bus_done_o <= 1'b0;
    l1_desc_o <= ~l1_word_i;
    l2_desc_o <= ~l2_word_i;
    bus_error_o <= ~err_i;
    if (!bus_req_i) phase <= 1'b0;
    if ((walk_l1_i || walk_l2_i || bus_req_i) &&
        !(l1_valid_o || l2_valid_o || bus_done_o)) begin
      if (wait_cnt < delay_i) wait_cnt <= wait_cnt + 2'h1;
      else begin
        wait_cnt <= 2'h0;
        if (walk_l1_i) begin
          l1_valid_o <= 1'b1;
          l1_desc_o <= l1_word_i;
        end else if (walk_l2_i) begin
          l2_valid_o <= 1'b1;
          l2_desc_o <= l2_word_i;
        end else begin
          bus_done_o <= 1'b1;
          bus_error_o <= err_i && !phase;
          phase <= 1'b1;
        end
      end
    end
  end
endmodule

// File: testbench/tb.sv
// Testbench that drives core accesses and checks aborts and codes.
`timescale 1ns/1ns
module tb;
  import fault_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        req_valid = 1'b0;
  logic        err = 1'b0;
  logic [1:0]  dly = 2'h0;
  logic [31:0] l1w = 32'h0;
  logic [31:0] l2w = 32'h0;
  access_t     rq = '0;
  ctrl_t       ct = '0;
  logic        done, abort, wl1, wl2, breq, l1v, l2v, bdone, berr;
  logic [31:0] l1d, l2d, phys;
  fault_t      flt;
  int          n_errors = 0;
  int          samples_checked = 0;
  int          nph = 0;

  always #5 clk = ~clk;
  always @(posedge clk) if (bdone === 1'b1) nph++;

  mmu_fault_checker mmu_fault_checker_inst (
    .core_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(req_valid),
    .req_i(rq), .ctrl_i(ct), .l1_valid_i(l1v), .l1_desc_i(l1d),
    .l2_valid_i(l2v), .l2_desc_i(l2d), .bus_done_i(bdone),
    .bus_error_i(berr), .walk_l1_o(wl1), .walk_l2_o(wl2),
    .bus_req_o(breq), .done_o(done), .abort_o(abort), .fault_o(flt),
    .phys_addr_o(phys));
  core_mem_model core_mem_model_inst (
    .clk_i(clk), .walk_l1_i(wl1), .walk_l2_i(wl2), .bus_req_i(breq),
    .l1_word_i(l1w), .l2_word_i(l2w), .err_i(err), .delay_i(dly),
    .l1_valid_o(l1v), .l1_desc_o(l1d), .l2_valid_o(l2v),
    .l2_desc_o(l2d), .bus_done_o(bdone), .bus_error_o(berr));

  task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask

  task give_verdict;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Flags are write, user, fetch, locked; cb is cachable, bufferable.
  task go(input logic [31:0] a, input acc_size_t s, input logic [3:0] f,
          input logic [1:0] cb, input logic ea, input logic [3:0] ec,
          input int ep);
    int i;
    @(negedge clk);
    rq = '{a, s, f[3], f[2], f[1], cb[1], cb[0], f[0]};
    req_valid = 1'b1;
    nph = 0;
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 40 && done !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (done !== 1'b1) begin
      check("done", 32'h1, 32'h0);
      give_verdict;
    end
    check("abort", {31'h0, ea}, {31'h0, abort});
    if (ea) check("code", {28'h0, ec}, {28'h0, flt.code});
    check("phases", 32'(ep), 32'(nph));
  endtask

  function automatic logic ok_perm(logic [1:0] ap, logic s, logic r,
                                   logic u, logic w);
    if (s && r) return 1'b0;
    case (ap)
      2'h0: return s ? (!u && !w) : (r && !w);
      2'h1: return !u;
      2'h2: return !(u && w);
      default: return 1'b1;
    endcase
  endfunction

  function automatic logic [31:0] sec(logic [1:0] ap, logic [3:0] dom);
    return {12'h123, 8'h00, ap, 1'b0, dom, 3'h0, 2'h2};
  endfunction

  function automatic logic [31:0] crs(logic [3:0] dom, logic b4);
    return {23'h0, dom, b4, 2'h0, 2'h1};
  endfunction

  initial begin
    int k;
    logic ok;
    ct = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 32'h0000_1e00};
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    go(32'h102, SIZE_WORD, 4'h0, 2'h0, 1, FS_ALIGN, 0);
    go(32'h101, SIZE_HALF, 4'h8, 2'h0, 1, FS_ALIGN, 0);
    go(32'h103, SIZE_BYTE, 4'h0, 2'h0, 0, FS_NONE, 1);
    check("phys", 32'h103, phys);
    go(32'h102, SIZE_WORD, 4'h2, 2'h0, 0, FS_NONE, 1);
    @(negedge clk);
    ct.mmu_en = 1'b1;
    go(32'h102, SIZE_WORD, 4'h0, 2'h0, 1, FS_ALIGN, 0);
    go(32'h100, SIZE_WORD, 4'h0, 2'h0, 1, FS_TRANS_SEC, 0);
    dly = 2'h2;
    l1w = sec(2'h3, 4'd3);
    go(32'h100, SIZE_WORD, 4'h0, 2'h0, 1, FS_DOM_SEC, 0);
    check("domain", 32'h3, {28'h0, flt.domain});
    l1w = sec(2'h3, 4'd4);
    go(32'h100, SIZE_WORD, 4'h0, 2'h0, 1, FS_DOM_SEC, 0);
    l1w = sec(2'h0, 4'd5);
    go(32'h100, SIZE_WORD, 4'hc, 2'h0, 0, FS_NONE, 1);
    check("phys", 32'h1230_0100, phys);
    for (k = 0; k < 64; k++) begin
      @(negedge clk);
      ct.sys_prot = k[3];
      ct.rom_prot = k[2];
      l1w = sec(k[5:4], 4'd6);
      ok = ok_perm(k[5:4], k[3], k[2], k[1], k[0]);
      go(32'h200, SIZE_WORD, {k[0], k[1], 2'h0}, 2'h0, !ok,
         FS_PERM_SEC, ok ? 1 : 0);
    end
    @(negedge clk);
    {ct.sys_prot, ct.rom_prot} = 2'h0;
    l1w = crs(4'd6, 1'b0);
    go(32'h100, SIZE_WORD, 4'h0, 2'h0, 1, FS_TRANS_PAGE, 0);
    l1w = crs(4'd3, 1'b0);
    go(32'h100, SIZE_WORD, 4'h0, 2'h0, 1, FS_DOM_PAGE, 0);
    check("domain", 32'h3, {28'h0, flt.domain});
    l1w = crs(4'd6, 1'b0);
    for (k = 0; k < 8; k++) begin
      l2w = {20'h45678, 8'h1b, 2'h0, k[2] ? L2_LARGE : L2_SMALL};
      go(k[2] ? {16'h0, k[1:0], 14'h0} : {20'h0, k[1:0], 10'h0},
         SIZE_WORD, 4'h4, 2'h0, k[1], FS_PERM_PAGE,
         k[1] ? 0 : 1);
    end
    check("phys", 32'h4567_4000, phys);
    l1w = crs(4'd6, 1'b1);
    l2w = {30'h0, L2_TINY};
    go(32'h100, SIZE_WORD, 4'h4, 2'h0, 1, FS_PERM_PAGE, 0);
    go(32'h100, SIZE_WORD, 4'h8, 2'h0, 0, FS_NONE, 1);
    check("phys", 32'h0000_0100, phys);
    @(negedge clk);
    {ct.mmu_en, ct.dcache_en} = 2'h0;
    err = 1'b1;
    go(32'h300, SIZE_WORD, 4'h0, 2'h0, 1, FS_EXT_SEC, 1);
    go(32'h300, SIZE_WORD, 4'h0, 2'h2, 0, FS_NONE, 1);
    go(32'h300, SIZE_WORD, 4'h8, 2'h1, 0, FS_NONE, 1);
    go(32'h300, SIZE_WORD, 4'h8, 2'h0, 1, FS_EXT_SEC, 1);
    go(32'h300, SIZE_WORD, 4'h1, 2'h0, 1, FS_EXT_SEC, 1);
    err = 1'b0;
    go(32'h300, SIZE_WORD, 4'h1, 2'h0, 0, FS_NONE, 2);
    give_verdict;
  end
endmodule
